// ==== rtl/bfdma_pkg.sv ====
// package: register map, field layout, targets, carriers of the burst fifo dma engine
package bfdma_pkg;
    localparam int BURST_BEATS = 8;
    localparam int FIFO_BYTES = 32;
    localparam int BEAT_BYTES = 4;
    // register byte offsets
    localparam logic [11:0] OFS_IRQ_CTRL_NORM = 12'h000;
    localparam logic [11:0] OFS_IRQ_CTRL_ERR = 12'h004;
    localparam logic [11:0] OFS_SRC_ATTR = 12'h008;
    localparam logic [11:0] OFS_DST_ATTR = 12'h00c;
    localparam logic [11:0] OFS_GEN_CTRL = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT_NORM = 12'h014;
    localparam logic [11:0] OFS_IRQ_STAT_ERR = 12'h018;
    localparam logic [11:0] OFS_RUN_CTRL = 12'h01c;
    localparam logic [11:0] OFS_MODE_STAT = 12'h020;
    localparam logic [11:0] OFS_SRC_ADDR = 12'h024;
    localparam logic [11:0] OFS_DST_ADDR = 12'h028;
    localparam logic [11:0] OFS_XFER_CNT = 12'h02c;
    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [31:0] RST_REG32 = 32'h0000_0000;
    // field positions
    localparam int BIT_RUN_START = 0;
    localparam int BIT_GEN_ENABLE = 0;
    localparam int BIT_IRQ_ENABLE = 0;
    localparam int BIT_STAT_DONE = 0;
    localparam int BIT_ERR_READ = 1;
    localparam int BIT_ERR_WRITE = 2;
    // attribute target select, bits 1:0
    typedef enum logic [1:0] {
        TGT_BACKPLANE = 2'h0,
        TGT_SHARED_RAM = 2'h1,
        TGT_IO_PORT = 2'h2,
        TGT_NONE = 2'h3
    } bfdma_tgt_e;
    // transfer size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    typedef struct packed {
        logic req;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bfdma_req_s;
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } bfdma_rsp_s;
endpackage : bfdma_pkg

// ==== rtl/bfdma_top.sv ====
// burst fifo dma engine: apb registers, burst sequencer, staging fifo
`timescale 1ns/1ps
module bfdma_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_ff;
    logic [AW:0] rdPtr_ff;
    logic push;
    logic pop;
    assign level = wrPtr_ff - rdPtr_ff;
    assign inReady = (level != (AW+1)'(DEPTH));
    assign outValid = (level != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_ff[AW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (rst || flush) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (push) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (pop) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two");
    end
endmodule : bfdma_fifo

module bfdma_top
    import bfdma_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_BYTES / BEAT_BYTES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output bfdma_req_s bpOut,
    input wire bfdma_rsp_s bpIn,
    output logic bpBusy,
    output bfdma_req_s ramOut,
    input wire bfdma_rsp_s ramIn,
    output logic lbReq,
    input wire logic lbGrant,
    input wire logic cpuBpReq,
    output logic cpuBpGrant,
    input wire logic ioInValid,
    output logic ioInReady,
    input wire logic [7:0] ioInData,
    output logic ioOutValid,
    input wire logic ioOutReady,
    output logic [7:0] ioOutData,
    output logic irqNormal,
    output logic irqError
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_YIELD} bfdma_state_e;
    bfdma_state_e state_ff;
    logic [7:0] ctlNorm_ff, ctlErr_ff, srcAttr_ff, dstAttr_ff, genCtrl_ff, statNorm_ff, statErr_ff;
    logic [31:0] srcAddr_ff, dstAddr_ff, count_ff;
    logic [3:0] burstBeats_ff, beatsLeft_ff;
    logic longBurst_ff, accActive_ff;
    logic [31:0] accAddr_ff, accData_ff;
    bfdma_tgt_e srcTgt, dstTgt, curTgt;
    logic apbWr, apbRd, startCmd, curAck, curErr, canIssue, beatDone;
    logic [31:0] curRdata;
    logic [2:0] stepBytes;
    logic [3:0] nxt_beats;
    logic nxt_long;
    logic fifoInReady, fifoOutValid;
    logic [31:0] fifoOut;
    logic [$clog2(FIFO_DEPTH):0] fifoLevel;
    logic flush;

    if (FIFO_DEPTH * BEAT_BYTES != FIFO_BYTES) begin : g_depth_chk
        $error("staging fifo must hold exactly one burst");
    end

    // apb slave, zero wait states
    assign pready = 1'b1;
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && penable && !pwrite;
    assign startCmd = apbWr && paddr == OFS_RUN_CTRL && pwdata[BIT_RUN_START]
        && genCtrl_ff[BIT_GEN_ENABLE] && state_ff == ST_IDLE;
    always_comb begin
        pslverr = 1'b0;
        prdata = 32'h0000_0000;
        unique case (paddr)
            OFS_IRQ_CTRL_NORM: prdata = {24'h000000, ctlNorm_ff};
            OFS_IRQ_CTRL_ERR: prdata = {24'h000000, ctlErr_ff};
            OFS_SRC_ATTR: prdata = {24'h000000, srcAttr_ff};
            OFS_DST_ATTR: prdata = {24'h000000, dstAttr_ff};
            OFS_GEN_CTRL: prdata = {24'h000000, genCtrl_ff};
            OFS_IRQ_STAT_NORM: prdata = {24'h000000, statNorm_ff};
            OFS_IRQ_STAT_ERR: prdata = {24'h000000, statErr_ff};
            OFS_RUN_CTRL: prdata = {31'h00000000, state_ff != ST_IDLE};
            OFS_MODE_STAT: prdata = {24'h000000, longBurst_ff, fifoLevel, 1'b0, state_ff};
            OFS_SRC_ADDR: prdata = srcAddr_ff;
            OFS_DST_ADDR: prdata = dstAddr_ff;
            OFS_XFER_CNT: prdata = count_ff;
            default: pslverr = psel && penable;
        endcase
    end
    // software control registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctlNorm_ff <= RST_REG8;
            ctlErr_ff <= RST_REG8;
            srcAttr_ff <= RST_REG8;
            dstAttr_ff <= RST_REG8;
            genCtrl_ff <= RST_REG8;
        end else if (apbWr) begin
            if (paddr == OFS_IRQ_CTRL_NORM) ctlNorm_ff <= pwdata[7:0];
            if (paddr == OFS_IRQ_CTRL_ERR) ctlErr_ff <= pwdata[7:0];
            if (paddr == OFS_SRC_ATTR && state_ff == ST_IDLE) srcAttr_ff <= pwdata[7:0];
            if (paddr == OFS_DST_ATTR && state_ff == ST_IDLE) dstAttr_ff <= pwdata[7:0];
            if (paddr == OFS_GEN_CTRL) genCtrl_ff <= pwdata[7:0];
        end
    end

    assign srcTgt = bfdma_tgt_e'(srcAttr_ff[1:0]);
    assign dstTgt = bfdma_tgt_e'(dstAttr_ff[1:0]);
    assign curTgt = (state_ff == ST_WRITE) ? dstTgt : srcTgt;
    // burst sizing from current alignment and remaining count
    always_comb begin
        nxt_long = srcAddr_ff[1:0] == 2'h0 && dstAddr_ff[1:0] == 2'h0 && count_ff >= 32'h4
            && srcTgt != TGT_IO_PORT && dstTgt != TGT_IO_PORT;
        if (nxt_long) begin
            nxt_beats = (count_ff[31:2] >= 30'h8) ? 4'h8 : count_ff[5:2];
        end else if (srcAddr_ff[1:0] == dstAddr_ff[1:0] && srcAddr_ff[1:0] != 2'h0 && count_ff > 32'h3) begin
            nxt_beats = 4'h4 - {2'h0, srcAddr_ff[1:0]};
        end else begin
            nxt_beats = (count_ff >= 32'h8) ? 4'h8 : count_ff[3:0];
        end
    end
    assign stepBytes = longBurst_ff ? 3'h4 : 3'h1;
    // response mux of the addressed target
    always_comb begin
        curAck = 1'b0;
        curErr = 1'b0;
        curRdata = 32'h0000_0000;
        unique case (curTgt)
            TGT_BACKPLANE: begin
                curAck = bpIn.ack;
                curErr = bpIn.err;
                curRdata = bpIn.rdata;
            end
            TGT_SHARED_RAM: begin
                curAck = ramIn.ack;
                curErr = ramIn.err;
                curRdata = ramIn.rdata;
            end
            TGT_IO_PORT: begin
                curAck = (state_ff == ST_READ) ? ioInValid : ioOutReady;
                curRdata = {24'h000000, ioInData};
            end
            TGT_NONE: curErr = 1'b1;
        endcase
    end
    assign beatDone = accActive_ff && (curAck || curErr);
    // reads wait for room, writes for data, ram waits for grant
    assign canIssue = !accActive_ff && beatsLeft_ff != 4'h0
        && (state_ff == ST_READ ? fifoInReady : (state_ff == ST_WRITE && fifoOutValid))
        && (curTgt != TGT_SHARED_RAM || lbGrant);
    // sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            burstBeats_ff <= 4'h0;
            beatsLeft_ff <= 4'h0;
            longBurst_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: if (startCmd && count_ff != 32'h0) begin
                    state_ff <= ST_READ;
                    burstBeats_ff <= nxt_beats;
                    beatsLeft_ff <= nxt_beats;
                    longBurst_ff <= nxt_long;
                end
                ST_READ: if (beatDone && curErr) begin
                    state_ff <= ST_IDLE;
                end else if (beatDone && beatsLeft_ff == 4'h1) begin
                    state_ff <= ST_WRITE;
                    beatsLeft_ff <= burstBeats_ff;
                end else if (beatDone) begin
                    beatsLeft_ff <= beatsLeft_ff - 4'h1;
                end
                ST_WRITE: if (beatDone && curErr) begin
                    state_ff <= ST_IDLE;
                end else if (beatDone && beatsLeft_ff == 4'h1) begin
                    beatsLeft_ff <= 4'h0;
                    if (count_ff == 32'(stepBytes)) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        state_ff <= ST_YIELD;
                    end
                end else if (beatDone) begin
                    beatsLeft_ff <= beatsLeft_ff - 4'h1;
                end
                // next burst sized only once address and count have stepped
                ST_YIELD: if (!cpuBpReq) begin
                    state_ff <= ST_READ;
                    burstBeats_ff <= nxt_beats;
                    beatsLeft_ff <= nxt_beats;
                    longBurst_ff <= nxt_long;
                end
            endcase
        end
    end
    // one access in flight at a time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accActive_ff <= 1'b0;
            accAddr_ff <= RST_REG32;
            accData_ff <= RST_REG32;
        end else if (beatDone) begin
            accActive_ff <= 1'b0;
        end else if (canIssue) begin
            accActive_ff <= 1'b1;
            accAddr_ff <= (state_ff == ST_READ) ? srcAddr_ff : dstAddr_ff;
            accData_ff <= fifoOut;
        end
    end
    // address and count bookkeeping
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            srcAddr_ff <= RST_REG32;
            dstAddr_ff <= RST_REG32;
            count_ff <= RST_REG32;
        end else if (state_ff == ST_IDLE) begin
            if (apbWr && paddr == OFS_SRC_ADDR) srcAddr_ff <= pwdata;
            if (apbWr && paddr == OFS_DST_ADDR) dstAddr_ff <= pwdata;
            if (apbWr && paddr == OFS_XFER_CNT) count_ff <= pwdata;
        end else if (beatDone && !curErr) begin
            if (state_ff == ST_READ) begin
                srcAddr_ff <= srcAddr_ff + 32'(stepBytes);
            end else begin
                dstAddr_ff <= dstAddr_ff + 32'(stepBytes);
                count_ff <= count_ff - 32'(stepBytes);
            end
        end
    end
    // termination status, set wins over start clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            statNorm_ff <= RST_REG8;
            statErr_ff <= RST_REG8;
        end else begin
            if (startCmd) begin
                statNorm_ff <= RST_REG8;
                statErr_ff <= RST_REG8;
            end
            if (state_ff == ST_WRITE && beatDone && !curErr && beatsLeft_ff == 4'h1
                    && count_ff == 32'(stepBytes)) begin
                statNorm_ff[BIT_STAT_DONE] <= 1'b1;
            end
            if (beatDone && curErr) begin
                statErr_ff[BIT_STAT_DONE] <= 1'b1;
                statErr_ff[BIT_ERR_READ] <= state_ff == ST_READ;
                statErr_ff[BIT_ERR_WRITE] <= state_ff == ST_WRITE;
            end
        end
    end
    assign irqNormal = statNorm_ff[BIT_STAT_DONE] && ctlNorm_ff[BIT_IRQ_ENABLE];
    assign irqError = statErr_ff[BIT_STAT_DONE] && ctlErr_ff[BIT_IRQ_ENABLE];
    assign flush = state_ff == ST_IDLE || (beatDone && curErr);

    bfdma_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_stage (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(flush),
        .inValid(state_ff == ST_READ && beatDone && !curErr),
        .inReady(fifoInReady),
        .inData(longBurst_ff ? curRdata : {24'h000000, curRdata[7:0]}),
        .outValid(fifoOutValid),
        .outReady(state_ff == ST_WRITE && beatDone && !curErr),
        .outData(fifoOut),
        .level(fifoLevel)
    );
    // target request outputs
    always_comb begin
        bpOut = '0;
        ramOut = '0;
        bpOut.write = state_ff == ST_WRITE;
        bpOut.size = longBurst_ff ? SIZE_LONG : SIZE_BYTE;
        bpOut.addr = accAddr_ff;
        bpOut.wdata = accData_ff;
        ramOut.write = bpOut.write;
        ramOut.size = bpOut.size;
        ramOut.addr = accAddr_ff;
        ramOut.wdata = accData_ff;
        bpOut.req = accActive_ff && curTgt == TGT_BACKPLANE;
        ramOut.req = accActive_ff && curTgt == TGT_SHARED_RAM && lbGrant;
    end
    assign lbReq = (state_ff == ST_READ || state_ff == ST_WRITE) && curTgt == TGT_SHARED_RAM;
    assign bpBusy = (state_ff == ST_READ || state_ff == ST_WRITE) && curTgt == TGT_BACKPLANE;
    assign cpuBpGrant = cpuBpReq && (state_ff == ST_IDLE || state_ff == ST_YIELD);
    assign ioInReady = accActive_ff && state_ff == ST_READ && curTgt == TGT_IO_PORT;
    assign ioOutValid = accActive_ff && state_ff == ST_WRITE && curTgt == TGT_IO_PORT;
    assign ioOutData = accData_ff[7:0];
    // checks
    property p_fullBurst;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_WRITE && $past(state_ff) == ST_READ) |-> fifoLevel == burstBeats_ff;
    endproperty
    a_fullBurst: assert property (p_fullBurst) else $error("burst not fully staged");
    property p_burstLen;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_READ) |-> (burstBeats_ff <= 4'h8 && burstBeats_ff != 4'h0);
    endproperty
    a_burstLen: assert property (p_burstLen) else $error("burst length out of range");
    property p_noMix;
        @(posedge sys_clk) disable iff (rst)
        (accActive_ff && state_ff == ST_READ) |-> !bpOut.write && !ioOutValid;
    endproperty
    a_noMix: assert property (p_noMix) else $error("write during read phase");
    property p_ramGrant;
        @(posedge sys_clk) disable iff (rst)
        ramOut.req |-> lbReq && lbGrant;
    endproperty
    a_ramGrant: assert property (p_ramGrant) else $error("ram cycle without grant");
    property p_bpReleased;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_WRITE && dstTgt == TGT_SHARED_RAM) |-> !bpBusy && !bpOut.req;
    endproperty
    a_bpReleased: assert property (p_bpReleased) else $error("backplane held during ram write");
    property p_localFree;
        @(posedge sys_clk) disable iff (rst)
        bpOut.req |-> !lbReq;
    endproperty
    a_localFree: assert property (p_localFree) else $error("local bus taken for backplane");
    property p_cpuHeld;
        @(posedge sys_clk) disable iff (rst)
        cpuBpGrant |-> fifoLevel == '0 && !bpBusy;
    endproperty
    a_cpuHeld: assert property (p_cpuHeld) else $error("grant with buffer not empty");
    property p_aligned;
        @(posedge sys_clk) disable iff (rst)
        (bpOut.req || ramOut.req) && bpOut.size == SIZE_LONG |-> accAddr_ff[1:0] == 2'h0;
    endproperty
    a_aligned: assert property (p_aligned) else $error("long transfer unaligned");
    property p_countStep;
        @(posedge sys_clk) disable iff (rst)
        (state_ff == ST_WRITE && beatDone && !curErr)
            |=> count_ff == $past(count_ff) - 32'($past(stepBytes));
    endproperty
    a_countStep: assert property (p_countStep) else $error("count did not step");
    property p_errEnd;
        @(posedge sys_clk) disable iff (rst)
        (beatDone && curErr) |=> state_ff == ST_IDLE ##0 statErr_ff[BIT_STAT_DONE];
    endproperty
    a_errEnd: assert property (p_errEnd) else $error("error did not terminate");
    c_normalEnd: cover property (@(posedge sys_clk) disable iff (rst) $rose(statNorm_ff[BIT_STAT_DONE]));
    c_errorEnd: cover property (@(posedge sys_clk) disable iff (rst) $rose(statErr_ff[BIT_STAT_DONE]));
    c_yield: cover property (@(posedge sys_clk) disable iff (rst) state_ff == ST_YIELD);
    c_byteBurst: cover property (@(posedge sys_clk) disable iff (rst) state_ff == ST_READ && !longBurst_ff);
endmodule : bfdma_top

// ==== tb/bfdma_partner.sv ====
// far side model: backplane board or shared ram with local bus grant
`timescale 1ns/1ps
module bfdma_partner
    import bfdma_pkg::*;
#(
    parameter logic [7:0] SEED = 8'h00
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire bfdma_req_s busReq,
    output bfdma_rsp_s busRsp,
    input wire logic lbReq,
    output logic lbGrant,
    input wire logic [3:0] dly,
    input wire logic failNow
);
    logic [31:0] mem [16];
    logic [3:0] wait_ff;
    logic [3:0] idx;
    assign idx = busReq.addr[5:2];
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {SEED, 24'(i * 3 + 1)};
        end
    end
    always @(posedge sys_clk) begin
        lbGrant <= !rst && lbReq;
    end
    // rdata toggles outside an answer so stale data never looks valid
    always @(posedge sys_clk) begin
        busRsp.ack <= 1'b0;
        busRsp.err <= 1'b0;
        busRsp.rdata <= ~busRsp.rdata;
        if (rst) begin
            wait_ff <= 4'h0;
            busRsp.rdata <= 32'h0;
        end else if (busReq.req && !busRsp.ack && !busRsp.err) begin
            if (wait_ff < dly) begin
                wait_ff <= wait_ff + 4'h1;
            end else begin
                wait_ff <= 4'h0;
                busRsp.ack <= !failNow;
                busRsp.err <= failNow;
                if (!failNow && busReq.write && busReq.size == SIZE_LONG) begin
                    mem[idx] <= busReq.wdata;
                end else if (!failNow && busReq.write) begin
                    mem[idx][8*busReq.addr[1:0] +: 8] <= busReq.wdata[7:0];
                end else if (busReq.size == SIZE_LONG) begin
                    busRsp.rdata <= mem[idx];
                end else begin
                    busRsp.rdata <= {24'h0, mem[idx][8*busReq.addr[1:0] +: 8]};
                end
            end
        end
    end
endmodule : bfdma_partner

// ==== tb/tb.sv ====
// testbench of the burst fifo dma engine
`timescale 1ns/1ps
module tb import bfdma_pkg::*; ;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    bfdma_req_s bpOut, ramOut;
    bfdma_rsp_s bpIn, ramIn;
    logic bpBusy, lbReq, lbGrant, cpuBpReq = 0, cpuBpGrant, irqNormal, irqError;
    logic ioInValid = 0, ioInReady, ioOutValid, ioOutReady = 1, failNow = 0, burstChk = 0;
    logic [7:0] ioInData = 8'ha0, ioOutData;
    logic [3:0] dly = 0;
    logic rdAck, wrAck;
    int errors = 0, checksDone = 0, rdN = 0, wrN = 0, longN = 0, k = 0;
    logic [31:0] ioGot = 32'h0;
    always #5 sys_clk = ~sys_clk;
    bfdma_top u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bpOut(bpOut),
        .bpIn(bpIn), .bpBusy(bpBusy), .ramOut(ramOut), .ramIn(ramIn), .lbReq(lbReq), .lbGrant(lbGrant),
        .cpuBpReq(cpuBpReq), .cpuBpGrant(cpuBpGrant), .ioInValid(ioInValid), .ioInReady(ioInReady),
        .ioInData(ioInData), .ioOutValid(ioOutValid), .ioOutReady(ioOutReady), .ioOutData(ioOutData),
        .irqNormal(irqNormal), .irqError(irqError));
    bfdma_partner #(.SEED(8'h5b)) u_bp (.sys_clk(sys_clk), .rst(rst), .busReq(bpOut), .busRsp(bpIn),
        .lbReq(1'b0), .lbGrant(), .dly(dly), .failNow(failNow));
    bfdma_partner #(.SEED(8'hc4)) u_ram (.sys_clk(sys_clk), .rst(rst), .busReq(ramOut), .busRsp(ramIn),
        .lbReq(lbReq), .lbGrant(lbGrant), .dly(dly), .failNow(1'b0));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(r, x);
    endtask : rd
    task automatic waitHi(ref logic s);
        @(posedge sys_clk);
        for (int i = 0; i < 3000 && s !== 1'b1; i++) @(posedge sys_clk);
        chk(s, 1);
    endtask : waitHi
    task run(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n, input logic [1:0] sa,
        input logic [1:0] da);
        wr(OFS_SRC_ATTR, sa);
        wr(OFS_DST_ATTR, da);
        wr(OFS_SRC_ADDR, s);
        wr(OFS_DST_ADDR, d);
        wr(OFS_XFER_CNT, n);
        wr(OFS_RUN_CTRL, 32'h1);
    endtask : run
    assign rdAck = (bpIn.ack && !bpOut.write) || (ramIn.ack && !ramOut.write);
    assign wrAck = (bpIn.ack && bpOut.write) || (ramIn.ack && ramOut.write);
    always @(posedge sys_clk) begin
        if (!rst) begin
            chk(ramOut.req & ~lbGrant, 0);
            chk(ramOut.req & bpBusy, 0);
            chk(lbReq & bpOut.req, 0);
            chk(cpuBpGrant & bpOut.req, 0);
            if (burstChk && rdAck) rdN++;
            if (burstChk && wrAck) begin
                if (wrN == 0) chk(rdN, 8);
                wrN++;
                if (wrN == rdN) begin
                    rdN = 0;
                    wrN = 0;
                end
            end
        end
    end
    always @(posedge sys_clk) begin
        if (ioInValid && ioInReady) ioInData <= ioInData + 8'h01;
        if (ioOutValid && ioOutReady) ioGot <= {ioOutData, ioGot[31:8]};
        if (ramIn.ack && ramOut.size == SIZE_LONG) longN++;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        for (int i = 0; i < 12; i++) rd(12'(i * 4), 32'h0);
        apb(0, 12'h030, 0);
        chk(e, 1);
        wr(OFS_IRQ_STAT_NORM, 32'hff);
        rd(OFS_IRQ_STAT_NORM, 32'h0);
        wr(OFS_IRQ_CTRL_NORM, 32'h1);
        wr(OFS_IRQ_CTRL_ERR, 32'h1);
        wr(OFS_GEN_CTRL, 32'h1);
        rd(OFS_IRQ_CTRL_ERR, 32'h1);
        // two bursts backplane to ram, cpu asks for the backplane meanwhile
        burstChk <= 1;
        run(0, 0, 64, TGT_BACKPLANE, TGT_SHARED_RAM);
        cpuBpReq <= 1;
        waitHi(cpuBpGrant);
        cpuBpReq <= 0;
        waitHi(irqNormal);
        for (int i = 0; i < 16; i++) chk(u_ram.mem[i], u_bp.mem[i]);
        rd(OFS_SRC_ADDR, 32'd64);
        rd(OFS_XFER_CNT, 32'h0);
        rd(OFS_IRQ_STAT_NORM, 32'h1);
        // ram to backplane with a slow far side
        dly <= 4'h3;
        run(0, 32'h20, 32, TGT_SHARED_RAM, TGT_BACKPLANE);
        waitHi(irqNormal);
        for (int i = 0; i < 8; i++) chk(u_bp.mem[8 + i], u_ram.mem[i]);
        burstChk <= 0;
        // bus error on the source side
        failNow <= 1;
        run(32'h10, 0, 32, TGT_BACKPLANE, TGT_SHARED_RAM);
        waitHi(irqError);
        failNow <= 0;
        chk(irqNormal, 0);
        rd(OFS_IRQ_STAT_ERR, 32'h3);
        // unaligned copy: byte lead-in, one long word, byte tail
        k = longN;
        run(32'h1, 32'h21, 8, TGT_BACKPLANE, TGT_SHARED_RAM);
        waitHi(irqNormal);
        chk(longN - k, 1);
        chk(u_ram.mem[8][31:8], u_bp.mem[0][31:8]);
        chk(u_ram.mem[9], u_bp.mem[1]);
        chk(u_ram.mem[10][7:0], u_bp.mem[2][7:0]);
        // io port source into ram as byte transfers
        dly <= 4'h0;
        ioInValid <= 1;
        run(0, 32'h3c, 4, TGT_IO_PORT, TGT_SHARED_RAM);
        waitHi(irqNormal);
        ioInValid <= 0;
        chk(u_ram.mem[15], 32'ha3a2a1a0);
        // shared ram drained into the io port
        run(32'h3c, 0, 4, TGT_SHARED_RAM, TGT_IO_PORT);
        waitHi(irqNormal);
        chk(ioGot, 32'ha3a2a1a0);
        tally_and_finish;
    end
endmodule : tb
